//--- verilog/cpu_core_register_set.sv
// Dedicated CPU core register set with APB access, flag logic and interrupt gating
// Overview of operation
// - Program counter resets to fffd
// - Accumulator is 16 bits; bytes use low half
// - Temporary accumulator pairs with accumulator in arithmetic
// - Index, extra pointer, stack pointer all 16 bits
// - Reset clears I and sets level mask 11
// - Status word: bank pointer high, codes low
// - Bank pointer selects active register bank address
// - Half carry from bit 3 into 4
// - Interrupts accepted only while I is set
// - Request must outrank the two-bit level mask
// - Negative flag follows result sign bit
// - Zero flag set on zero result
// - Overflow flag on two's-complement overflow
// - Carry out of bit 7 (bit 15 for word ops); shifts load shifted bit
// - Eight byte registers per bank, 32 banks
// - I/O lowest, data above, program highest
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ns
module cpu_core_register_set (
  // Clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt request from the controller
  input wire logic irq_req,
  input wire logic [1:0] irq_req_level,
  output logic irq_take,
  // Address of the selected general-purpose register
  output logic [15:0] bank_addr
);

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] ix;
    logic [15:0] ep;
    logic [15:0] sp;
    logic [7:0] rp;
    logic [7:0] condition_code_byte;
    logic [2:0] reg_num;
    logic [15:0] probe;
    logic [31:0] rdata;
    logic rd_valid;
  } core_state_t;

  // Undefined registers still reset to zero so simulation starts clean
  localparam core_state_t RESET_STATE = '{
    pc: core_regs_pkg::PC_RESET,
    acc: core_regs_pkg::WORD_ZERO,
    tmp: core_regs_pkg::WORD_ZERO,
    ix: core_regs_pkg::WORD_ZERO,
    ep: core_regs_pkg::WORD_ZERO,
    sp: core_regs_pkg::WORD_ZERO,
    rp: core_regs_pkg::BANK_RESET,
    condition_code_byte: core_regs_pkg::CCR_RESET,
    reg_num: 3'h0,
    probe: core_regs_pkg::WORD_ZERO,
    rdata: core_regs_pkg::DATA_ZERO,
    rd_valid: 1'b0
  };

  core_state_t st_reg;
  core_state_t st_next;
  core_link lk ();
  logic wr_fire;
  logic mapped;
  logic [31:0] read_word;
  logic [1:0] level_mask;
  core_regs_pkg::alu_op_t op_wr;

  result_flag_unit u_alu (
    .lk(lk.alu_side)
  );

  bank_address_map u_map (
    .lk(lk.map_side)
  );

  // Operands for the arithmetic unit come straight from the registers
  assign op_wr = core_regs_pkg::alu_op_t'(pwdata[2:0]);
  assign lk.op = (wr_fire && paddr == core_regs_pkg::OFF_OP) ? op_wr : core_regs_pkg::OP_NONE;
  assign lk.a = st_reg.acc;
  assign lk.t = st_reg.tmp;
  assign lk.cin = st_reg.condition_code_byte[core_regs_pkg::CCR_C];
  assign lk.bank_ptr = st_reg.rp;
  assign lk.reg_num = st_reg.reg_num;
  assign lk.probe_addr = st_reg.probe;
  assign bank_addr = lk.bank_addr;

  // Lower numeric level means higher priority; 00 lets nothing through
  assign level_mask = {st_reg.condition_code_byte[core_regs_pkg::CCR_IL1], st_reg.condition_code_byte[core_regs_pkg::CCR_IL0]};
  assign irq_take = irq_req && st_reg.condition_code_byte[core_regs_pkg::CCR_I] && (irq_req_level < level_mask);

  // Address decode for the register window
  always_comb begin
    case (paddr)
      core_regs_pkg::OFF_PC, core_regs_pkg::OFF_ACC, core_regs_pkg::OFF_TMP,
      core_regs_pkg::OFF_IX, core_regs_pkg::OFF_EP, core_regs_pkg::OFF_SP,
      core_regs_pkg::OFF_PSW, core_regs_pkg::OFF_OP, core_regs_pkg::OFF_BANKSEL,
      core_regs_pkg::OFF_PROBE, core_regs_pkg::OFF_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Read data selection; reserved bits and unmapped words read zero
  always_comb begin
    read_word = core_regs_pkg::DATA_ZERO;
    case (paddr)
      core_regs_pkg::OFF_PC: read_word = {16'h0000, st_reg.pc};
      core_regs_pkg::OFF_ACC: read_word = {16'h0000, st_reg.acc};
      core_regs_pkg::OFF_TMP: read_word = {16'h0000, st_reg.tmp};
      core_regs_pkg::OFF_IX: read_word = {16'h0000, st_reg.ix};
      core_regs_pkg::OFF_EP: read_word = {16'h0000, st_reg.ep};
      core_regs_pkg::OFF_SP: read_word = {16'h0000, st_reg.sp};
      core_regs_pkg::OFF_PSW: read_word = {16'h0000, st_reg.rp, st_reg.condition_code_byte};
      core_regs_pkg::OFF_BANKSEL: read_word = {lk.bank_addr, 13'h0000, st_reg.reg_num};
      core_regs_pkg::OFF_PROBE: read_word = {14'h0000, lk.region, st_reg.probe};
      core_regs_pkg::OFF_STATUS: read_word = {31'h0000_0000, irq_take};
      default: read_word = core_regs_pkg::DATA_ZERO;
    endcase
  end

  // Reads are sampled into a flop first, so the answer waits one edge after setup
  assign pready = clk_en && (pwrite || st_reg.rd_valid);
  assign pslverr = psel && penable && pready && !mapped;
  assign prdata = st_reg.rdata;
  assign wr_fire = psel && penable && pwrite && pready && mapped;

  // Next-state logic for every register
  always_comb begin
    st_next = st_reg;
    st_next.rd_valid = psel && !pwrite && !(penable && pready);
    if (psel && !pwrite) begin
      st_next.rdata = read_word;
    end
    if (wr_fire) begin
      case (paddr)
        core_regs_pkg::OFF_PC: st_next.pc = pwdata[15:0];
        core_regs_pkg::OFF_ACC: st_next.acc = pwdata[15:0];
        core_regs_pkg::OFF_TMP: st_next.tmp = pwdata[15:0];
        core_regs_pkg::OFF_IX: st_next.ix = pwdata[15:0];
        core_regs_pkg::OFF_EP: st_next.ep = pwdata[15:0];
        core_regs_pkg::OFF_SP: st_next.sp = pwdata[15:0];
        core_regs_pkg::OFF_PSW: begin
          st_next.rp = pwdata[15:8];
          st_next.condition_code_byte = pwdata[7:0];
        end
        core_regs_pkg::OFF_BANKSEL: st_next.reg_num = pwdata[2:0];
        core_regs_pkg::OFF_PROBE: st_next.probe = pwdata[15:0];
        core_regs_pkg::OFF_OP: begin
          if (op_wr != core_regs_pkg::OP_NONE) begin
            st_next.acc = lk.result;
            st_next.condition_code_byte[core_regs_pkg::CCR_N] = lk.n;
            st_next.condition_code_byte[core_regs_pkg::CCR_Z] = lk.z;
            st_next.condition_code_byte[core_regs_pkg::CCR_C] = lk.c;
          end
          // Shifts leave half carry and overflow alone
          if (op_wr inside {core_regs_pkg::OP_ADD8, core_regs_pkg::OP_SUB8,
                            core_regs_pkg::OP_ADD16, core_regs_pkg::OP_SUB16}) begin
            st_next.condition_code_byte[core_regs_pkg::CCR_H] = lk.h;
            st_next.condition_code_byte[core_regs_pkg::CCR_V] = lk.v;
          end
        end
        default: st_next = st_next;
      endcase
    end
  end

  // State register; a low clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= RESET_STATE;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // Checks on the register set
  logic op_add8;
  logic op_arith8;
  logic op_shl8;
  logic op_sub8;
  logic op_sub16;
  assign op_add8 = wr_fire && paddr == core_regs_pkg::OFF_OP && op_wr == core_regs_pkg::OP_ADD8;
  assign op_sub8 = wr_fire && paddr == core_regs_pkg::OFF_OP && op_wr == core_regs_pkg::OP_SUB8;
  assign op_sub16 = wr_fire && paddr == core_regs_pkg::OFF_OP && op_wr == core_regs_pkg::OP_SUB16;
  assign op_arith8 = wr_fire && paddr == core_regs_pkg::OFF_OP &&
                     (op_wr == core_regs_pkg::OP_ADD8 || op_wr == core_regs_pkg::OP_SUB8);
  assign op_shl8 = wr_fire && paddr == core_regs_pkg::OFF_OP && op_wr == core_regs_pkg::OP_SHL8;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Checked one edge later: at the very first edge the reset may not have reached the flops yet
  a_pc_reset_value: assert property (@(posedge pclk) disable iff (1'b0)
    !presetn |=> st_reg.pc == core_regs_pkg::PC_RESET && !st_reg.condition_code_byte[core_regs_pkg::CCR_I] &&
    st_reg.condition_code_byte[core_regs_pkg::CCR_IL1] && st_reg.condition_code_byte[core_regs_pkg::CCR_IL0])
    else $error("program counter or interrupt bits wrong during reset");
  a_irq_blocked: assert property (!st_reg.condition_code_byte[core_regs_pkg::CCR_I] |-> !irq_take)
    else $error("interrupt taken while disabled");
  a_irq_level: assert property (irq_take |-> irq_req_level < level_mask)
    else $error("interrupt taken at a level the mask forbids");
  a_acc_high_kept: assert property (op_arith8 |=> st_reg.acc[15:8] == $past(st_reg.acc[15:8]))
    else $error("byte operation changed the accumulator high byte");
  a_add_carry: assert property (op_add8 |=>
    st_reg.condition_code_byte[0] == (({1'b0, $past(st_reg.acc[7:0])} + {1'b0, $past(st_reg.tmp[7:0])}) > 9'h0ff))
    else $error("carry flag wrong after byte add");
  a_half_carry: assert property (op_add8 |=>
    st_reg.condition_code_byte[7] == (({1'b0, $past(st_reg.acc[3:0])} + {1'b0, $past(st_reg.tmp[3:0])}) > 5'h0f))
    else $error("half carry flag wrong after byte add");
  a_zero_neg: assert property (op_arith8 |=>
    st_reg.condition_code_byte[2] == (st_reg.acc[7:0] == 8'h00) && st_reg.condition_code_byte[3] == st_reg.acc[7])
    else $error("zero or negative flag disagrees with result");
  a_overflow_add: assert property (op_add8 ##1 $past(st_reg.acc[7]) == $past(st_reg.tmp[7])
    |-> st_reg.condition_code_byte[1] == (st_reg.acc[7] != $past(st_reg.acc[7])))
    else $error("overflow flag wrong after byte add");
  a_shift_carry: assert property (op_shl8 |=> st_reg.condition_code_byte[0] == $past(st_reg.acc[7]))
    else $error("shift did not load carry with the bit shifted out");
  a_bank_split: assert property (wr_fire && paddr == core_regs_pkg::OFF_PSW |=>
    st_reg.rp == $past(pwdata[15:8]) &&
    bank_addr == core_regs_pkg::BANK_BASE + {core_regs_pkg::BYTE_ZERO, $past(pwdata[12:8]), st_reg.reg_num})
    else $error("bank pointer or bank address wrong after status write");
  a_region_order: assert property (lk.region == core_regs_pkg::REGION_PROG |->
    st_reg.probe >= core_regs_pkg::PROG_BASE)
    else $error("program region reported below the program area");
  a_sub_borrow: assert property (op_sub8 |=>
    st_reg.condition_code_byte[core_regs_pkg::CCR_C] == ($past(st_reg.acc[7:0]) < $past(st_reg.tmp[7:0])))
    else $error("carry flag does not show the borrow after byte subtract");
  a_sub16_half: assert property (op_sub16 |=>
    st_reg.condition_code_byte[core_regs_pkg::CCR_H] == ($past(st_reg.acc[3:0]) < $past(st_reg.tmp[3:0])))
    else $error("half carry does not show the nibble borrow after word subtract");
  // The left shift must not disturb the arithmetic-only flags
  a_shift_hv_kept: assert property (op_shl8 |=>
    st_reg.condition_code_byte[core_regs_pkg::CCR_H] == $past(st_reg.condition_code_byte[core_regs_pkg::CCR_H]) &&
    st_reg.condition_code_byte[core_regs_pkg::CCR_V] == $past(st_reg.condition_code_byte[core_regs_pkg::CCR_V]))
    else $error("shift changed half carry or overflow");

  c_add8: cover property (op_add8 ##1 st_reg.condition_code_byte[0]);
  c_shift: cover property (op_shl8);
  c_irq: cover property (irq_take);
  c_read: cover property (psel && penable && pready && !pwrite);
  c_bus_error: cover property (pslverr);

endmodule : cpu_core_register_set

//--- verilog/core_regs_pkg.sv
// Constants, types and helper functions shared by the CPU core register set
package core_regs_pkg;

  // APB register offsets (byte addresses, one aligned word each)
  localparam logic [11:0] OFF_PC = 12'h000;
  localparam logic [11:0] OFF_ACC = 12'h004;
  localparam logic [11:0] OFF_TMP = 12'h008;
  localparam logic [11:0] OFF_IX = 12'h00c;
  localparam logic [11:0] OFF_EP = 12'h010;
  localparam logic [11:0] OFF_SP = 12'h014;
  localparam logic [11:0] OFF_PSW = 12'h018;
  localparam logic [11:0] OFF_OP = 12'h01c;
  localparam logic [11:0] OFF_BANKSEL = 12'h020;
  localparam logic [11:0] OFF_PROBE = 12'h024;
  localparam logic [11:0] OFF_STATUS = 12'h028;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'hfffd;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BANK_RESET = 8'h00;
  // Interrupts off, level mask 11 so requests at levels 0 to 2 outrank it once I is set
  localparam logic [7:0] CCR_RESET = 8'h30;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // Condition code byte bit positions
  localparam int CCR_H = 7;
  localparam int CCR_I = 6;
  localparam int CCR_IL1 = 5;
  localparam int CCR_IL0 = 4;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;

  // Memory map of the 64-Kbyte space and bank placement
  localparam logic [15:0] IO_TOP = 16'h007f;
  localparam logic [15:0] PROG_BASE = 16'h8000;
  localparam logic [15:0] BANK_BASE = 16'h0100;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Arithmetic operations started by a write to the operation register
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ADD8 = 3'h1,
    OP_SUB8 = 3'h2,
    OP_ADD16 = 3'h3,
    OP_SUB16 = 3'h4,
    OP_SHL8 = 3'h5,
    OP_SHR8 = 3'h6
  } alu_op_t;

  typedef enum logic [1:0] {
    REGION_IO = 2'h0,
    REGION_DATA = 2'h1,
    REGION_PROG = 2'h2
  } region_t;

  // Bank register address: base plus bank number times eight plus register number
  function automatic logic [15:0] bank_reg_addr(input logic [7:0] rp, input logic [2:0] rn);
    return BANK_BASE + {BYTE_ZERO, rp[4:0], rn};
  endfunction : bank_reg_addr

  // Which area of the address space an address falls in
  function automatic region_t region_of(input logic [15:0] addr);
    if (addr <= IO_TOP) return REGION_IO;
    if (addr >= PROG_BASE) return REGION_PROG;
    return REGION_DATA;
  endfunction : region_of

endpackage : core_regs_pkg

//--- verilog/core_link.sv
// Links the register set to its arithmetic flag unit and address mapper
`timescale 1ns/1ns
interface core_link;
  core_regs_pkg::alu_op_t op;
  logic [15:0] a;
  logic [15:0] t;
  logic cin;
  logic [15:0] result;
  logic n;
  logic z;
  logic v;
  logic c;
  logic h;
  logic [7:0] bank_ptr;
  logic [2:0] reg_num;
  logic [15:0] probe_addr;
  logic [15:0] bank_addr;
  core_regs_pkg::region_t region;

  modport core_side (output op, a, t, cin, bank_ptr, reg_num, probe_addr,
                     input result, n, z, v, c, h, bank_addr, region);
  modport alu_side (input op, a, t, cin, output result, n, z, v, c, h);
  modport map_side (input bank_ptr, reg_num, probe_addr, output bank_addr, region);
endinterface : core_link

//--- verilog/result_flag_unit.sv
// Arithmetic and shift unit that produces a result and its condition flags
`timescale 1ns/1ns
module result_flag_unit (
  // Operands in, result and flags out
  core_link.alu_side lk
);
  logic [8:0] sum8;
  logic [16:0] sum16;
  logic [4:0] nib;

  // Wide sums keep the carry or borrow out in the top bit
  always_comb begin
    sum8 = 9'h000;
    sum16 = 17'h00000;
    nib = 5'h00;
    lk.result = lk.a;
    lk.n = 1'b0;
    lk.z = 1'b0;
    lk.v = 1'b0;
    lk.c = lk.cin;
    lk.h = 1'b0;
    case (lk.op)
      core_regs_pkg::OP_ADD8, core_regs_pkg::OP_SUB8: begin
        if (lk.op == core_regs_pkg::OP_ADD8) begin
          sum8 = {1'b0, lk.a[7:0]} + {1'b0, lk.t[7:0]};
          nib = {1'b0, lk.a[3:0]} + {1'b0, lk.t[3:0]};
          lk.v = (lk.a[7] == lk.t[7]) && (sum8[7] != lk.a[7]);
        end else begin
          sum8 = {1'b0, lk.a[7:0]} - {1'b0, lk.t[7:0]};
          nib = {1'b0, lk.a[3:0]} - {1'b0, lk.t[3:0]};
          lk.v = (lk.a[7] != lk.t[7]) && (sum8[7] != lk.a[7]);
        end
        lk.result = {lk.a[15:8], sum8[7:0]};
        lk.h = nib[4];
        lk.c = sum8[8];
        lk.n = sum8[7];
        lk.z = (sum8[7:0] == 8'h00);
      end
      core_regs_pkg::OP_ADD16, core_regs_pkg::OP_SUB16: begin
        // Half carry follows the operation: a subtract reports the nibble borrow
        if (lk.op == core_regs_pkg::OP_ADD16) begin
          sum16 = {1'b0, lk.a} + {1'b0, lk.t};
          nib = {1'b0, lk.a[3:0]} + {1'b0, lk.t[3:0]};
          lk.v = (lk.a[15] == lk.t[15]) && (sum16[15] != lk.a[15]);
        end else begin
          sum16 = {1'b0, lk.a} - {1'b0, lk.t};
          nib = {1'b0, lk.a[3:0]} - {1'b0, lk.t[3:0]};
          lk.v = (lk.a[15] != lk.t[15]) && (sum16[15] != lk.a[15]);
        end
        lk.result = sum16[15:0];
        lk.h = nib[4];
        lk.c = sum16[16];
        lk.n = sum16[15];
        lk.z = (sum16[15:0] == 16'h0000);
      end
      // Shifts rotate through carry so the bit shifted out lands in C
      core_regs_pkg::OP_SHL8: begin
        lk.result = {lk.a[15:8], lk.a[6:0], lk.cin};
        lk.c = lk.a[7];
        lk.n = lk.a[6];
        lk.z = ({lk.a[6:0], lk.cin} == 8'h00);
      end
      core_regs_pkg::OP_SHR8: begin
        lk.result = {lk.a[15:8], lk.cin, lk.a[7:1]};
        lk.c = lk.a[0];
        lk.n = lk.cin;
        lk.z = ({lk.cin, lk.a[7:1]} == 8'h00);
      end
      default: begin
        lk.result = lk.a;
      end
    endcase
  end
endmodule : result_flag_unit

//--- verilog/bank_address_map.sv
// Converts the bank pointer to a register address and classifies addresses
`timescale 1ns/1ns
module bank_address_map (
  // Pointer and probe in, addresses out
  core_link.map_side lk
);
  // Only the low five pointer bits matter: there are at most 32 banks
  always_comb begin
    lk.bank_addr = core_regs_pkg::bank_reg_addr(lk.bank_ptr, lk.reg_num);
    lk.region = core_regs_pkg::region_of(lk.probe_addr);
  end
endmodule : bank_address_map

//--- dv/cpu_core_register_set_tb.sv
// Self-checking testbench for the CPU core register set over APB
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end
module cpu_core_register_set_tb;
  // Clock, reset and freeze
  logic pclk;
  logic presetn;
  logic clk_en;
  // APB master side
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Interrupt and bank outputs
  logic irq_req;
  logic [1:0] irq_req_level;
  logic irq_take;
  logic [15:0] bank_addr;
  // Bench bookkeeping
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;

  cpu_core_register_set uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .irq_req_level(irq_req_level), .irq_take(irq_take), .bank_addr(bank_addr));

  // 125 MHz clock
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // Hang guard: the whole run needs far fewer cycles than this
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task stop_test;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // One APB transfer, entered just after a rising edge; waits for pready however long it takes
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Reset held four cycles, then reset values read back
  task do_reset;
    presetn <= 1'b0;
    irq_req <= 1'b1;
    irq_req_level <= 2'h0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    `CHK("irq_take_in_reset", 1'b0, irq_take)
    `CHK("bank_addr_in_reset", core_regs_pkg::BANK_BASE, bank_addr)
    @(posedge pclk);
    presetn <= 1'b1;
    irq_req <= 1'b0;
    @(posedge pclk);
    apb(1'b0, core_regs_pkg::OFF_PC, 32'h0, rd, er);
    `CHK("pc_reset", 32'h0000_fffd, rd)
    apb(1'b0, core_regs_pkg::OFF_PSW, 32'h0, rd, er);
    `CHK("psw_i_il_reset", 3'b011, rd[6:4])
  endtask : do_reset

  // Sixteen-bit registers keep 16 bits and read zero above
  task t_regs;
    logic [11:0] offs [6];
    offs = '{core_regs_pkg::OFF_PC, core_regs_pkg::OFF_ACC, core_regs_pkg::OFF_TMP,
             core_regs_pkg::OFF_IX, core_regs_pkg::OFF_EP, core_regs_pkg::OFF_SP};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, offs[i], {16'hffff, 4'(i), 12'ha5c}, rd, er);
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, offs[i], 32'h0, rd, er);
      `CHK("reg_readback", {16'h0000, 4'(i), 12'ha5c}, rd)
    end
  endtask : t_regs

  // Load operands and flags, start one operation, then check result and condition byte
  task alu(input logic [2:0] op, input logic [15:0] a, input logic [15:0] t, input logic [7:0] cin,
           input logic [15:0] ea, input logic [7:0] ec);
    apb(1'b1, core_regs_pkg::OFF_ACC, {16'h0000, a}, rd, er);
    apb(1'b1, core_regs_pkg::OFF_TMP, {16'h0000, t}, rd, er);
    apb(1'b1, core_regs_pkg::OFF_PSW, {24'h0, cin}, rd, er);
    apb(1'b1, core_regs_pkg::OFF_OP, {29'h0, op}, rd, er);
    apb(1'b0, core_regs_pkg::OFF_ACC, 32'h0, rd, er);
    `CHK("alu_result", {16'h0000, ea}, rd)
    apb(1'b0, core_regs_pkg::OFF_PSW, 32'h0, rd, er);
    `CHK("alu_flags", ec, rd[7:0])
  endtask : alu

  // Flag cases: sign, zero, overflow, carry, half carry and shifts through carry
  task t_alu;
    alu(core_regs_pkg::OP_ADD8, 16'h127f, 16'h0001, 8'h30, 16'h1280, 8'hba);
    alu(core_regs_pkg::OP_ADD8, 16'h00ff, 16'h0001, 8'h30, 16'h0000, 8'hb5);
    alu(core_regs_pkg::OP_SUB8, 16'h0005, 16'h0005, 8'h30, 16'h0000, 8'h34);
    alu(core_regs_pkg::OP_SUB8, 16'h0080, 16'h0001, 8'h30, 16'h007f, 8'hb2);
    alu(core_regs_pkg::OP_SUB8, 16'h1201, 16'h0002, 8'h30, 16'h12ff, 8'hb9);
    alu(core_regs_pkg::OP_SUB16, 16'h0000, 16'h0001, 8'h30, 16'hffff, 8'hb9);
    alu(core_regs_pkg::OP_ADD16, 16'h7fff, 16'h0001, 8'h30, 16'h8000, 8'hba);
    alu(core_regs_pkg::OP_ADD8, 16'h0008, 16'h0008, 8'h30, 16'h0010, 8'hb0);
    alu(core_regs_pkg::OP_SHL8, 16'h1281, 16'h0000, 8'h31, 16'h1203, 8'h31);
    alu(core_regs_pkg::OP_SHR8, 16'h0001, 16'h0000, 8'h30, 16'h0000, 8'h35);
  endtask : t_alu

  // Bank pointer in the status word selects the register address
  task bank(input logic [7:0] rp, input logic [2:0] rn, input logic [15:0] ea);
    apb(1'b1, core_regs_pkg::OFF_PSW, {16'h0000, rp, 8'h30}, rd, er);
    apb(1'b1, core_regs_pkg::OFF_BANKSEL, {29'h0, rn}, rd, er);
    apb(1'b0, core_regs_pkg::OFF_BANKSEL, 32'h0, rd, er);
    `CHK("banksel_read", {ea, 13'h0, rn}, rd)
    @(negedge pclk);
    `CHK("bank_addr_port", ea, bank_addr)
    @(posedge pclk);
  endtask : bank

  task t_bank;
    bank(8'h25, 3'h3, core_regs_pkg::BANK_BASE + 16'h002b);
    bank(8'h1f, 3'h7, core_regs_pkg::BANK_BASE + 16'h00ff);
    bank(8'he0, 3'h0, core_regs_pkg::BANK_BASE);
  endtask : t_bank

  // Area boundaries of the address space
  task t_probe;
    logic [15:0] ad [4];
    logic [1:0] rg [4];
    ad = '{core_regs_pkg::IO_TOP, core_regs_pkg::IO_TOP + 16'h1, core_regs_pkg::PROG_BASE - 16'h1,
           core_regs_pkg::PROG_BASE};
    rg = '{2'h0, 2'h1, 2'h1, 2'h2};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, core_regs_pkg::OFF_PROBE, {16'h0000, ad[i]}, rd, er);
      apb(1'b0, core_regs_pkg::OFF_PROBE, 32'h0, rd, er);
      `CHK("probe_region", {14'h0, rg[i], ad[i]}, rd)
    end
  endtask : t_probe

  // Enable flag and level mask gate requests at every level
  task t_irq;
    apb(1'b1, core_regs_pkg::OFF_PSW, 32'h0000_0060, rd, er);
    for (int l = 0; l < 4; l++) begin
      irq_req <= 1'b1;
      irq_req_level <= 2'(l);
      @(negedge pclk);
      `CHK("irq_take_level", (l < 2), irq_take)
      @(posedge pclk);
      apb(1'b0, core_regs_pkg::OFF_STATUS, 32'h0, rd, er);
      `CHK("status_take", (l < 2), rd[0])
    end
    irq_req_level <= 2'h0;
    apb(1'b1, core_regs_pkg::OFF_PSW, 32'h0000_0030, rd, er);
    @(negedge pclk);
    `CHK("irq_blocked_i0", 1'b0, irq_take)
    @(posedge pclk);
    irq_req <= 1'b0;
  endtask : t_irq

  // Unmapped and misaligned addresses answer with an error and read zero
  task t_bad;
    apb(1'b1, 12'h02c, 32'hffff_ffff, rd, er);
    `CHK("unmapped_wr_err", 1'b1, er)
    apb(1'b0, 12'h02c, 32'h0, rd, er);
    `CHK("unmapped_rd_data", 32'h0, rd)
    `CHK("unmapped_rd_err", 1'b1, er)
    apb(1'b0, 12'h006, 32'h0, rd, er);
    `CHK("misaligned_err", 1'b1, er)
  endtask : t_bad

  // Freeze in mid-write: pready waits for clk_en, the write still lands once
  task t_stall;
    clk_en <= 1'b0;
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= core_regs_pkg::OFF_SP;
    pwdata <= 32'h0000_4321;
    @(posedge pclk);
    penable <= 1'b1;
    repeat (3) begin
      @(posedge pclk);
      `CHK("pready_frozen", 1'b0, pready)
    end
    clk_en <= 1'b1;
    @(posedge pclk);
    `CHK("pready_thawed", 1'b1, pready)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    apb(1'b0, core_regs_pkg::OFF_SP, 32'h0, rd, er);
    `CHK("sp_after_stall", 32'h0000_4321, rd)
  endtask : t_stall

  // Main sequence, ending with a second reset
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq_req = 1'b0;
    irq_req_level = 2'h0;
    do_reset();
    t_regs();
    t_alu();
    t_bank();
    t_probe();
    t_irq();
    t_bad();
    t_stall();
    do_reset();
    stop_test();
  end
endmodule : cpu_core_register_set_tb
